// ==== include/panel_pkg.sv ====
// Purpose : shared constants and types for the local key and led panel
// Assumes : mclk at 200 MHz
// Notes   : times are named in ms, counts derived from the clock rate
package panel_pkg;
    localparam int unsigned CLK_HZ         = 200_000_000;
    localparam int unsigned SHORT_LIMIT_MS = 2000;
    localparam int unsigned TEST_HOLD_MS   = 4000;
    localparam int unsigned CHECK_MIN_MS   = 10000;
    localparam int unsigned RESULT_MS      = 12000;
    localparam int unsigned DEBOUNCE_MS    = 10;
    localparam int unsigned SLOW_HALF_MS   = 500;
    localparam int unsigned FAST_HALF_MS   = 100;
    localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned SHORT_LIMIT_CYC = SHORT_LIMIT_MS * CYC_PER_MS;
    localparam int unsigned TEST_HOLD_CYC   = TEST_HOLD_MS * CYC_PER_MS;
    localparam int unsigned CHECK_MIN_CYC   = CHECK_MIN_MS * CYC_PER_MS;
    localparam int unsigned RESULT_CYC      = RESULT_MS * CYC_PER_MS;
    localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
    localparam int unsigned SLOW_HALF_CYC   = SLOW_HALF_MS * CYC_PER_MS;
    localparam int unsigned FAST_HALF_CYC   = FAST_HALF_MS * CYC_PER_MS;
    localparam int unsigned CODE_W          = 32;
    localparam logic [1:0]  SEL_WIRELESS    = 2'h0;
    localparam logic [1:0]  SEL_TEST        = 2'h1;
    localparam logic [1:0]  SEL_LOCK        = 2'h2;
    localparam logic        RESET_LOCKED    = 1'b1;
    localparam logic        RESET_WIRELESS  = 1'b0;
    localparam logic        RESET_FULL_ROLE = 1'b1;
    typedef enum logic [2:0] {
        PT_IDLE, PT_RUN, PT_PASS, PT_FAIL, PT_REFUSED
    } pt_state_t;
endpackage : panel_pkg

// ==== include/key_if.sv ====
// Purpose : carries classified key events from key_classifier to the top
// Assumes : single mclk domain
// Notes   : all signals are one-cycle pulses
interface key_if;
    logic short_press;  // released before the short limit
    logic long_press;   // held past the short limit, pulsed once
    logic test_hold;    // held past the test limit, pulsed once
    modport src (output short_press, output long_press, output test_hold);
    modport dst (input short_press, input long_press, input test_hold);
endinterface : key_if

// ==== hw/key_classifier.sv ====
// Purpose : synchronise, debounce and time the operating key
// Assumes : key_n is an asynchronous pin, active low
// Notes   : long and test-hold events fire while the key is still held
module key_classifier
    import panel_pkg::*;
#(
    parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
    parameter int unsigned SHORT_CYC = SHORT_LIMIT_CYC,
    parameter int unsigned HOLD_CYC  = TEST_HOLD_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic key_n,
    key_if.src        ev
);
    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        stable;
        logic [31:0] deb;
        logic [31:0] held;
        logic        long_done;
        logic        hold_done;
        logic        sp;
        logic        lp;
        logic        th;
    } kc_t;
    kc_t st_r, st_nxt;

    // debounce then measure the press on the clean level
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = ~key_n;
        st_nxt.s2 = st_r.s1;
        st_nxt.sp = 1'b0;
        st_nxt.lp = 1'b0;
        st_nxt.th = 1'b0;
        if (st_r.s2 != st_r.stable) begin
            st_nxt.deb = st_r.deb + 32'h1;
            if (st_r.deb >= DEB_CYC) begin
                st_nxt.stable = st_r.s2;
                st_nxt.deb    = '0;
            end
        end else begin
            st_nxt.deb = '0;
        end
        if (st_r.stable) begin
            if (st_r.held != 32'hFFFFFFFF) begin
                st_nxt.held = st_r.held + 32'h1;
            end
            if (st_r.held >= SHORT_CYC && !st_r.long_done) begin
                st_nxt.lp        = 1'b1;
                st_nxt.long_done = 1'b1;
            end
            if (st_r.held >= HOLD_CYC && !st_r.hold_done) begin
                st_nxt.th        = 1'b1;
                st_nxt.hold_done = 1'b1;
            end
        end else begin
            // a release before the limit is a short press
            st_nxt.sp        = (st_r.held != '0) && !st_r.long_done;
            st_nxt.held      = '0;
            st_nxt.long_done = 1'b0;
            st_nxt.hold_done = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign ev.short_press = st_r.sp & ce;
    assign ev.long_press  = st_r.lp & ce;
    assign ev.test_hold   = st_r.th & ce;
endmodule : key_classifier

// ==== hw/flash_gen.sv ====
// Purpose : free running slow and fast flash square waves
// Assumes : ce freezes the phase
// Notes   : slow blink marks a selected active function, fast an inactive one
module flash_gen
    import panel_pkg::*;
#(
    parameter int unsigned SLOW_CYC = SLOW_HALF_CYC,
    parameter int unsigned FAST_CYC = FAST_HALF_CYC
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    output logic      slow,
    output logic      fast
);
    typedef struct packed {
        logic [31:0] sc;
        logic [31:0] fc;
        logic        slow;
        logic        fast;
    } fg_t;
    fg_t st_r, st_nxt;

    // two independent half-period dividers
    always_comb begin
        st_nxt    = st_r;
        st_nxt.sc = st_r.sc + 32'h1;
        st_nxt.fc = st_r.fc + 32'h1;
        if (st_r.sc >= SLOW_CYC - 1) begin
            st_nxt.sc   = '0;
            st_nxt.slow = ~st_r.slow;
        end
        if (st_r.fc >= FAST_CYC - 1) begin
            st_nxt.fc   = '0;
            st_nxt.fast = ~st_r.fast;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign slow = st_r.slow;
    assign fast = st_r.fast;
endmodule : flash_gen

// ==== hw/panel_ctrl.sv ====
// Purpose : local key and led panel controller with proof test and user roles
// Assumes : level and safety inputs come from logic on mclk
// Notes   : led outputs are registered; loop current demand is a flag
//
// Functional notes
// - short under 2 s, long beyond 2 s
// - short advances selection, long acts on it
// - selected led flashes, pattern shows active state
// - wireless enabled blocks local key operation
// - long on wireless toggles enable, led follows
// - lock led mirrors key lock state
// - unlock: long, shorts to lock, long
// - test led flashes while check runs
// - test starts only from OK 16 mA state
// - no test while output in demand
// - hold over 4 s on test launches check
// - check drives output to 8 mA demand
// - check lasts at least 10 s
// - pass: test led steady 12 s, others dark
// - fail: three leds fast flash 12 s
// - refused test: three leds flash together
// - two roles: full access and read only
// - start in full access role
// - set code gives read only, match restores
// - wrong code keeps read only rights
// - reversed serial resets code to original
module panel_ctrl
    import panel_pkg::*;
#(
    parameter int unsigned          CHECK_CYC = CHECK_MIN_CYC,
    parameter int unsigned          SHOW_CYC  = RESULT_CYC,
    parameter int unsigned          DEB_CYC   = DEBOUNCE_CYC,
    parameter int unsigned          SHORT_CYC = SHORT_LIMIT_CYC,
    parameter int unsigned          HOLD_CYC  = TEST_HOLD_CYC,
    parameter logic [CODE_W-1:0]    SERIAL_NO = 32'h1234ABCD  // arbitrary value
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              key_n,
    input  wire logic              safety_max,
    input  wire logic              sensor_covered,
    input  wire logic              check_ok,
    input  wire logic              check_done,
    input  wire logic              wireless_set,
    input  wire logic              wireless_clr,
    input  wire logic              code_assign,
    input  wire logic              code_enter,
    input  wire logic [CODE_W-1:0] code_value,
    output logic                   led_wireless,
    output logic                   led_test,
    output logic                   led_lock,
    output logic                   demand_out,
    output logic                   wireless_en,
    output logic                   key_locked,
    output logic                   full_access,
    output logic                   test_busy
);
    key_if kev ();

    logic slow;
    logic fast;

    key_classifier #(
        .DEB_CYC   (DEB_CYC),
        .SHORT_CYC (SHORT_CYC),
        .HOLD_CYC  (HOLD_CYC)
    ) u_key (
        .mclk  (mclk),
        .rst   (rst),
        .ce    (ce),
        .key_n (key_n),
        .ev    (kev)
    );

    flash_gen u_flash (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .slow (slow),
        .fast (fast)
    );

    // bit reversal of a code word, used for the reset code
    function automatic logic [CODE_W-1:0] rev_bits(input logic [CODE_W-1:0] v);
        logic [CODE_W-1:0] r;
        r = '0;
        for (int i = 0; i < CODE_W; i++) begin
            r[i] = v[CODE_W-1-i];
        end
        return r;
    endfunction : rev_bits

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              locked;
        logic              wl_en;
        logic              menu;
        logic [1:0]        sel;
        pt_state_t         pt;
        logic [31:0]       tmr;
        logic              got_done;
        logic              got_ok;
        logic              demand;
        logic              full;
        logic              has_code;
        logic [CODE_W-1:0] code;
        logic              led_w;
        logic              led_t;
        logic              led_l;
    } pc_t;
    pc_t st_r, st_nxt;

    logic ok_state;
    logic busy;

    // OK is 16 mA: max with fork free, or min with fork covered
    assign ok_state  = safety_max ^ sensor_covered;
    assign busy      = (st_r.pt != PT_IDLE);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // remote enable requests from the wireless side, overridden by a key action below
        if (wireless_set) begin
            st_nxt.wl_en = 1'b1;
        end else if (wireless_clr) begin
            st_nxt.wl_en = 1'b0;
        end

        // key navigation, dead while wireless is on or a test runs
        if (!st_r.wl_en && !busy) begin
            if (kev.long_press && !st_r.menu) begin
                st_nxt.menu = 1'b1;
                st_nxt.sel  = SEL_WIRELESS;
            end else if (kev.short_press && st_r.menu) begin
                st_nxt.sel = (st_r.sel == SEL_LOCK) ? SEL_WIRELESS
                                                   : st_r.sel + 2'h1;
            end else if (kev.long_press && st_r.menu) begin
                unique case (st_r.sel)
                    SEL_LOCK: begin
                        st_nxt.locked = ~st_r.locked;
                        st_nxt.menu   = 1'b0;
                    end
                    SEL_WIRELESS: begin
                        if (!st_r.locked) begin
                            st_nxt.wl_en = 1'b1;
                            st_nxt.menu  = 1'b0;
                        end
                    end
                    default: ; // test is launched by the longer hold
                endcase
            end else if (kev.test_hold && st_r.menu && st_r.sel == SEL_TEST &&
                         !st_r.locked) begin
                st_nxt.menu = 1'b0;
                st_nxt.tmr  = '0;
                if (ok_state) begin
                    st_nxt.pt       = PT_RUN;
                    st_nxt.demand   = 1'b1;
                    st_nxt.got_done = 1'b0;
                    st_nxt.got_ok   = 1'b0;
                end else begin
                    st_nxt.pt = PT_REFUSED;
                end
            end
        end else if (st_r.wl_en && kev.long_press &&
                     st_r.sel == SEL_WIRELESS) begin // menu closed on enable, selection kept
            st_nxt.wl_en = 1'b0;
            st_nxt.menu  = 1'b0;
        end

        // proof test sequencer
        unique case (st_r.pt)
            PT_IDLE: ;
            PT_RUN: begin
                st_nxt.tmr = st_r.tmr + 32'h1;
                if (check_done && !st_r.got_done) begin
                    st_nxt.got_done = 1'b1;
                    st_nxt.got_ok   = check_ok;
                end
                if (st_r.tmr >= CHECK_CYC - 1 && st_r.got_done) begin
                    st_nxt.tmr    = '0;
                    st_nxt.demand = 1'b0;
                    st_nxt.pt     = st_r.got_ok ? PT_PASS : PT_FAIL;
                end
            end
            PT_PASS, PT_FAIL, PT_REFUSED: begin
                st_nxt.tmr = st_r.tmr + 32'h1;
                if (st_r.tmr >= SHOW_CYC - 1) begin
                    st_nxt.tmr = '0;
                    st_nxt.pt  = PT_IDLE;
                end
            end
        endcase

        // access code and user role
        if (code_assign) begin
            st_nxt.code     = code_value;
            st_nxt.has_code = 1'b1;
            st_nxt.full     = 1'b0;
        end else if (code_enter) begin
            if (code_value == rev_bits(SERIAL_NO)) begin
                st_nxt.code     = SERIAL_NO;
                st_nxt.has_code = 1'b1;
            end else if (!st_r.has_code || code_value == st_r.code) begin
                st_nxt.full = 1'b1;
            end else begin
                st_nxt.full = 1'b0;
            end
        end

        // led drive
        st_nxt.led_w = st_nxt.wl_en;
        st_nxt.led_l = st_nxt.locked;
        st_nxt.led_t = 1'b0;
        if (st_r.menu) begin
            // slow blink when the selected function is on, fast when off
            unique case (st_r.sel)
                SEL_WIRELESS: st_nxt.led_w = st_r.wl_en ? slow : fast;
                SEL_TEST:     st_nxt.led_t = fast;
                SEL_LOCK:     st_nxt.led_l = st_r.locked ? slow : fast;
                default: ;
            endcase
        end
        unique case (st_r.pt)
            PT_IDLE: ;
            PT_RUN: st_nxt.led_t = slow;
            PT_PASS: begin
                st_nxt.led_t = 1'b1;
                st_nxt.led_w = 1'b0;
                st_nxt.led_l = 1'b0;
            end
            PT_FAIL: begin
                st_nxt.led_t = fast;
                st_nxt.led_w = fast;
                st_nxt.led_l = fast;
            end
            PT_REFUSED: begin
                st_nxt.led_t = slow;
                st_nxt.led_w = slow;
                st_nxt.led_l = slow;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r          <= '0;
            st_r.locked   <= RESET_LOCKED;
            st_r.wl_en    <= RESET_WIRELESS;
            st_r.full     <= RESET_FULL_ROLE;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign led_wireless = st_r.led_w;
    assign led_test     = st_r.led_t;
    assign led_lock     = st_r.led_l;
    assign demand_out   = st_r.demand;
    assign wireless_en  = st_r.wl_en;
    assign key_locked   = st_r.locked;
    assign full_access  = st_r.full;
    assign test_busy    = busy;
endmodule : panel_ctrl

// ==== tb/panel_ctrl_asserts.sv ====
// Purpose : concurrent checks on the panel controller ports
// Assumes : one mclk domain, rst asynchronous and active high
// Notes   : flash phases are too slow to see, so only leds moving together are judged
module panel_ctrl_asserts
    import panel_pkg::*;
#(
    parameter int unsigned CHECK_CYC = CHECK_MIN_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic safety_max,
    input wire logic sensor_covered,
    input wire logic check_ok,
    input wire logic code_assign,
    input wire logic code_enter,
    input wire logic led_wireless,
    input wire logic led_test,
    input wire logic led_lock,
    input wire logic demand_out,
    input wire logic wireless_en,
    input wire logic key_locked,
    input wire logic full_access,
    input wire logic test_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // demand duration counter
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    int unsigned run_r;
    int unsigned run_nxt;
    // counts cycles the forced demand has stood, so a short check is caught
    always_comb run_nxt = demand_out ? run_r + 1 : 0;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_r <= 0;
        end else begin
            run_r <= run_nxt;
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence s_check_over;
        $fell(demand_out);
    endsequence
    sequence s_pass_shown;
        led_test && !led_lock && !led_wireless;
    endsequence
    sequence s_all_alike;
        (led_test == led_lock) && (led_lock == led_wireless);
    endsequence
    chk_demand_busy: assert property (demand_out |-> test_busy)
        else $error("demand level seen outside a running check");
    chk_start_ok: assert property ($rose(demand_out) |-> $past(safety_max ^ sensor_covered))
        else $error("check started outside the ok output state");
    chk_check_min: assert property (s_check_over |-> run_r >= CHECK_CYC - 1)
        else $error("check ended before its minimum duration");
    chk_result_held: assert property (s_check_over |-> test_busy[*8])
        else $error("result display did not stand after the check");
    chk_pass_leds: assert property (s_check_over ##0 check_ok |-> ##[0:2] s_pass_shown[*4])
        else $error("pass pattern not shown");
    chk_fail_leds: assert property (s_check_over ##0 !check_ok |-> ##[0:2] s_all_alike[*4])
        else $error("fail leds not moving together");
    chk_lock_frozen: assert property (wireless_en |=> $stable(key_locked))
        else $error("key lock changed while wireless enabled");
    chk_assign_ro: assert property (code_assign |=> !full_access)
        else $error("code assign left full access");
    chk_role_rise: assert property ($rose(full_access) |-> $past(code_enter))
        else $error("full access granted without a code entry");
endmodule : panel_ctrl_asserts

// ==== tb/key_operator.sv ====
// Purpose : operator at the local key, presses and holds for set spans
// Assumes : key pin idles high through its pull-up while untouched
// Notes   : optional contact bounce of one-cycle pulses before a press
module key_operator (
    input  wire logic mclk,
    output logic      key_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial key_n = 1'b1;
    // press for hold cycles, release, then let the debouncer settle
    task automatic press(input int hold, input bit bounce);
        if (bounce) begin
            for (int i = 0; i < 3; i++) begin
                @(posedge mclk) key_n <= 1'b0;
                @(posedge mclk) key_n <= 1'b1;
            end
        end
        @(posedge mclk) key_n <= 1'b0;
        repeat (hold) @(posedge mclk);
        key_n <= 1'b1;
        repeat (20) @(posedge mclk);
    endtask : press
endmodule : key_operator

// ==== tb/panel_ctrl_tb.sv ====
// Purpose : self-checking bench for the panel controller
// Assumes : shortened counts, an action on a selection closes the menu
// Notes   : long press 70 cycles, short 20, test hold 130
module panel_ctrl_tb
    import panel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CODE_W-1:0] SERIAL = 32'h5A0F3C96;  // arbitrary value
    logic mclk, rst, ce, key_n, safety_max, sensor_covered, check_ok, check_done;
    logic wireless_set, wireless_clr, code_assign, code_enter;
    logic [CODE_W-1:0] code_value;
    logic led_wireless, led_test, led_lock, demand_out;
    logic wireless_en, key_locked, full_access, test_busy;
    int   num_errors;
    int   tests_run;
    // ----------------------------------------------------------------
    // design, operator and clock
    // ----------------------------------------------------------------
    panel_ctrl #(.CHECK_CYC(200), .SHOW_CYC(200), .DEB_CYC(4), .SHORT_CYC(50),
                 .HOLD_CYC(100), .SERIAL_NO(SERIAL)) dut_u (
        .mclk(mclk), .rst(rst), .ce(ce), .key_n(key_n), .safety_max(safety_max),
        .sensor_covered(sensor_covered), .check_ok(check_ok), .check_done(check_done),
        .wireless_set(wireless_set), .wireless_clr(wireless_clr),
        .code_assign(code_assign), .code_enter(code_enter), .code_value(code_value),
        .led_wireless(led_wireless), .led_test(led_test), .led_lock(led_lock),
        .demand_out(demand_out), .wireless_en(wireless_en), .key_locked(key_locked),
        .full_access(full_access), .test_busy(test_busy));
    key_operator op_u (.mclk(mclk), .key_n(key_n));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : do_reset
    // one-cycle pulse on the entry or assign strobe with a code
    task automatic give_code(input bit assign_it, input logic [CODE_W-1:0] v);
        @(posedge mclk);
        code_value <= v;
        if (assign_it) begin
            code_assign <= 1'b1;
        end else begin
            code_enter <= 1'b1;
        end
        @(posedge mclk);
        code_assign <= 1'b0;
        code_enter  <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : give_code
    task automatic pulse_done();
        @(posedge mclk) check_done <= 1'b1;
        @(posedge mclk) check_done <= 1'b0;
    endtask : pulse_done
    // open menu, step to lock, unlock, reopen and step to the test led
    task automatic to_test();
        op_u.press(70, 0);
        op_u.press(20, 0);
        op_u.press(20, 0);
        op_u.press(70, 0);
        op_u.press(70, 0);
        op_u.press(20, 0);
    endtask : to_test
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        do_reset();
        check("key_locked", key_locked, 1);
        check("led_lock", led_lock, 1);
        check("full_access", full_access, 1);
        check("demand_out", demand_out, 0);
        check("wireless_en", wireless_en, 0);
        $display("t_reset done");
    endtask : t_reset
    // bounce on a short press must not add a step
    task automatic t_unlock();
        do_reset();
        op_u.press(70, 0);
        op_u.press(20, 1);
        op_u.press(20, 0);
        check("locked after shorts", key_locked, 1);
        op_u.press(70, 0);
        check("unlocked", key_locked, 0);
        op_u.press(20, 1);
        check("lock led dark", led_lock, 0);
        $display("t_unlock done");
    endtask : t_unlock
    // menu is closed after the unlock, so reopen it on the wireless led first
    task automatic t_wireless();
        op_u.press(70, 0);
        op_u.press(70, 0);
        check("wireless on", wireless_en, 1);
        check("wireless led lit", led_wireless, 1);
        op_u.press(20, 0);
        op_u.press(70, 0);
        check("wireless off", wireless_en, 0);
        @(posedge mclk) wireless_set <= 1'b1;
        @(posedge mclk) wireless_set <= 1'b0;
        repeat (2) @(posedge mclk);
        check("remote on", wireless_en, 1);
        @(posedge mclk) wireless_clr <= 1'b1;
        @(posedge mclk) wireless_clr <= 1'b0;
        repeat (2) @(posedge mclk);
        check("remote off", wireless_en, 0);
        $display("t_wireless done");
    endtask : t_wireless
    task automatic t_proof(input bit ok, input bit smax, input bit cov);
        do_reset();
        safety_max     <= smax;
        sensor_covered <= cov;
        check_ok       <= ok;
        to_test();
        op_u.press(130, 0);
        check("demand forced", demand_out, 1);
        check("busy", test_busy, 1);
        repeat (80) @(posedge mclk);
        check("demand held", demand_out, 1);
        pulse_done();
        repeat (100) @(posedge mclk);
        pulse_done();
        repeat (4) @(posedge mclk);
        check("demand released", demand_out, 0);
        if (ok) begin
            check("led_test pass", led_test, 1);
            check("led_lock pass", led_lock, 0);
            check("led_wireless pass", led_wireless, 0);
        end else begin
            check("fail lock", led_lock, led_test);
            check("fail wireless", led_wireless, led_test);
        end
        repeat (150) @(posedge mclk);
        check("result stands", test_busy, 1);
        repeat (60) @(posedge mclk);
        check("back to normal", test_busy, 0);
        $display("t_proof done");
    endtask : t_proof
    task automatic t_refused();
        do_reset();
        safety_max     <= 1'b1;
        sensor_covered <= 1'b1;
        to_test();
        op_u.press(130, 0);
        check("no demand", demand_out, 0);
        check("refuse lock", led_lock, led_test);
        check("refuse wireless", led_wireless, led_test);
        $display("t_refused done");
    endtask : t_refused
    task automatic t_roles();
        logic [CODE_W-1:0] rev_code;
        rev_code = {<<{SERIAL}};
        do_reset();
        give_code(1, 32'hC0DE0042);
        check("read only", full_access, 0);
        give_code(0, 32'hC0DE0043);
        check("wrong code", full_access, 0);
        give_code(0, 32'hC0DE0042);
        check("code match", full_access, 1);
        give_code(1, 32'hC0DE0042);
        give_code(0, SERIAL);
        check("original stale", full_access, 0);
        give_code(0, rev_code);
        give_code(0, SERIAL);
        check("original again", full_access, 1);
        $display("t_roles done");
    endtask : t_roles
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        num_errors = 0;
        tests_run = 0;
        rst = 1'b1;
        ce = 1'b1;
        safety_max = 1'b1;
        sensor_covered = 1'b0;
        check_ok = 1'b1;
        check_done = 1'b0;
        wireless_set = 1'b0;
        wireless_clr = 1'b0;
        code_assign = 1'b0;
        code_enter = 1'b0;
        code_value = '0;
        @(posedge mclk);
        t_reset();
        t_unlock();
        t_wireless();
        t_proof(1, 1, 0);
        t_proof(0, 0, 1);
        t_refused();
        t_roles();
        finish_test();
    end
    // whole run needs about 3100 cycles; generous margin before cutting a hang
    initial begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
endmodule : panel_ctrl_tb

bind panel_ctrl panel_ctrl_asserts #(.CHECK_CYC(CHECK_CYC)) chk_u (
    .mclk(mclk), .rst(rst), .safety_max(safety_max), .sensor_covered(sensor_covered),
    .check_ok(check_ok), .code_assign(code_assign), .code_enter(code_enter),
    .led_wireless(led_wireless), .led_test(led_test), .led_lock(led_lock),
    .demand_out(demand_out), .wireless_en(wireless_en), .key_locked(key_locked),
    .full_access(full_access), .test_busy(test_busy));
